// *** pmups_ctrl.v ***
// Purpose: Power-state pin controller of a power-management unit
// Assumes: Pin inputs synchronous to i_clk; straps and OTP are static
// Notes:   Slow 32 kHz tick is an enable pulse from a divider
`include "pmups_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module pmups_ctrl #(
    parameter SLOW_DIV   = `PMUPS_SLOW_DIV,
    parameter LONG_TICKS = `PMUPS_LONG_S * `PMUPS_SLOW_HZ,
    parameter ACK_TICKS  = `PMUPS_ACK_S * `PMUPS_SLOW_HZ,
    parameter PULSE_TICKS = `PMUPS_PULSE_S * `PMUPS_SLOW_HZ
) (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst_n,
    // Avalon-MM slave
    input  wire [3:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    output reg  [31:0] o_avs_readdata,
    output reg         o_avs_waitrequest,
    // Pins and straps
    input  wire        i_lowpower_pin,
    input  wire        i_power_hold_input,
    input  wire        i_push_button_input,
    input  wire        i_voltage_monitor_output,
    input  wire        i_config_strap_b,
    input  wire        i_interface_select_strap,
    input  wire        i_io_supply_ok,
    input  wire        i_otp_button_reset_mode,
    input  wire        i_otp_int_open_drain,
    input  wire        i_otp_int_active_high,
    // Outputs
    output reg         o_processor_reset_output_n,
    output reg         o_slow_clock_output,
    output reg         o_slow_clock_output_oe,
    output reg         o_host_interrupt_output,
    output reg         o_host_interrupt_output_oe,
    output reg         o_spi_select,
    output reg         o_device_reset,
    output reg  [1:0]  o_power_state
);

    // ****************************************
    // States
    // ****************************************
    localparam [1:0] ST_OFF    = 2'h0;
    localparam [1:0] ST_SEQ    = 2'h1;
    localparam [1:0] ST_ACTIVE = 2'h2;
    localparam [1:0] ST_LOWPWR = 2'h3;

    reg [1:0]  state_reg, state_next;
    reg [11:0] div_reg;
    reg        tick_reg;
    reg        clk32_reg;
    reg [2:0]  sync1_reg, sync2_reg, prev_reg;
    reg [7:0]  deb_reg;
    reg        btn_reg;
    reg        btn_prev_reg;
    reg [17:0] long_reg;
    reg [17:0] ack_reg;
    reg [17:0] pulse_reg;
    reg        long_armed_reg;
    reg [4:0]  ctrl_reg;
    reg [3:0]  ctrl_b_reg;
    reg [2:0]  sts_reg;
    reg [2:0]  msk_reg;
    reg        lp_pin_at_entry_reg;
    reg        sts_prev_any_reg;
    reg        ack_pend_reg;

    wire lp_pin   = sync2_reg[0];
    wire hold     = sync2_reg[1];
    wire btn_raw  = sync2_reg[2];
    wire pending  = |sts_reg;
    wire unmasked = |(sts_reg & ~msk_reg);
    wire lp_req   = lp_pin ^ ~ctrl_b_reg[`PMUPS_CTRLB_PIN_POL];
    wire btn_fall = btn_prev_reg & ~btn_reg;
    wire wr = i_avs_write & ~o_avs_waitrequest;
    // Read data loads in the wait cycle so it stands at the accept edge
    wire rd = i_avs_read & o_avs_waitrequest;

    function sel;
        input [3:0] a;
        input [3:0] ofs;
        begin
            sel = (a == ofs);
        end
    endfunction

    // ****************************************
    // Slow clock divider and synchronisers
    // ****************************************
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_reg   <= 12'h000;
            tick_reg  <= 1'b0;
            clk32_reg <= 1'b0;
            // Idle levels: button released, hold low, pin low
            sync1_reg <= 3'h4;
            sync2_reg <= 3'h4;
            prev_reg  <= 3'h4;
        end else begin
            tick_reg <= 1'b0;
            if (div_reg == SLOW_DIV[11:0] - 12'h001) begin
                div_reg  <= 12'h000;
                tick_reg <= 1'b1;
                clk32_reg <= ~clk32_reg;
            end else begin
                div_reg <= div_reg + 12'h001;
            end
            if (tick_reg) begin
                // Level pins pass no filter, only the sync pair
                sync1_reg <= {i_push_button_input, i_power_hold_input,
                              i_lowpower_pin};
                sync2_reg <= sync1_reg;
                prev_reg  <= sync2_reg;
            end
        end
    end

    // ****************************************
    // Button debounce and timers
    // ****************************************
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            deb_reg        <= 8'h00;
            btn_reg        <= 1'b1;
            btn_prev_reg   <= 1'b1;
            long_reg       <= 18'h0_0000;
            long_armed_reg <= 1'b0;
        end else begin
            btn_prev_reg <= btn_reg;
            if (tick_reg) begin
                if (btn_raw == btn_reg)
                    deb_reg <= 8'h00;
                else if (deb_reg == `PMUPS_DEB_TICKS) begin
                    btn_reg <= btn_raw;
                    deb_reg <= 8'h00;
                end else
                    deb_reg <= deb_reg + 8'h01;
                if (btn_reg)
                    long_reg <= 18'h0_0000;
                else if (long_reg != LONG_TICKS[17:0])
                    long_reg <= long_reg + 18'h0_0001;
            end
            long_armed_reg <= (long_reg == LONG_TICKS[17:0]);
        end
    end

    // ****************************************
    // Registers over Avalon-MM, one wait cycle
    // ****************************************
    wire long_evt = (long_reg == LONG_TICKS[17:0]) & ~long_armed_reg
                    & ctrl_reg[`PMUPS_CTRL_LP_OFF];
    wire hold_r = tick_reg & hold & ~prev_reg[1];
    wire hold_f = tick_reg & ~hold & prev_reg[1];
    wire awake  = (state_reg == ST_ACTIVE) | (state_reg == ST_LOWPWR);
    wire [2:0] evt;
    assign evt[`PMUPS_INT_BUTTON] = awake & btn_fall;
    assign evt[`PMUPS_INT_LONGPR] = long_evt;
    assign evt[`PMUPS_INT_HOLD] =
        (hold_r & ctrl_b_reg[`PMUPS_CTRLB_HOLD_R]) |
        (hold_f & ctrl_b_reg[`PMUPS_CTRLB_HOLD_F]);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0000_0000;
            ctrl_reg          <= 5'h00;
            ctrl_b_reg        <= 4'h0;
            sts_reg           <= 3'h0;
            msk_reg           <= `PMUPS_MSK_RESET;
        end else begin
            o_avs_waitrequest <= ~((i_avs_read | i_avs_write)
                                   & o_avs_waitrequest);
            if (rd) begin
                o_avs_readdata <= 32'h0000_0000;
                if (sel(i_avs_address, `PMUPS_OFS_CTRL))
                    o_avs_readdata <= {27'h0, ctrl_reg};
                else if (sel(i_avs_address, `PMUPS_OFS_CTRL_B))
                    o_avs_readdata <= {28'h0, ctrl_b_reg};
                else if (sel(i_avs_address, `PMUPS_OFS_INT_STS))
                    o_avs_readdata <= {27'h0, state_reg, sts_reg};
                else if (sel(i_avs_address, `PMUPS_OFS_INT_MSK))
                    o_avs_readdata <= {29'h0, msk_reg};
            end
            // Self-clearing strobes
            ctrl_reg[`PMUPS_CTRL_SW_LP] <= 1'b0;
            ctrl_reg[`PMUPS_CTRL_LP_ACK] <= 1'b0;
            if (wr && sel(i_avs_address, `PMUPS_OFS_CTRL))
                ctrl_reg <= i_avs_writedata[4:0];
            if (wr && sel(i_avs_address, `PMUPS_OFS_CTRL_B))
                ctrl_b_reg <= i_avs_writedata[3:0];
            if (wr && sel(i_avs_address, `PMUPS_OFS_INT_MSK))
                msk_reg <= i_avs_writedata[2:0];
            // Write-one-to-clear; a new event wins over the clear
            if (wr && sel(i_avs_address, `PMUPS_OFS_INT_STS))
                sts_reg <= (sts_reg & ~i_avs_writedata[2:0]) | evt;
            else
                sts_reg <= sts_reg | evt;
        end
    end

    // ****************************************
    // Power state machine
    // ****************************************
    wire mon_ok = ~ctrl_reg[`PMUPS_CTRL_MON_SEQ] | i_voltage_monitor_output;
    wire new_int = pending & ~sts_prev_any_reg;
    wire on_req = hold | (btn_fall & ~i_otp_button_reset_mode)
                  | (pulse_reg != 18'h0_0000);

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: if (on_req) state_next = ST_SEQ;
            ST_SEQ: if (mon_ok) state_next = ST_ACTIVE;
            ST_ACTIVE: begin
                if (ctrl_reg[`PMUPS_CTRL_SW_LP] && !pending)
                    state_next = ST_LOWPWR;
                else if (i_config_strap_b && !pending && lp_req &&
                         ctrl_b_reg[`PMUPS_CTRLB_PIN_EN])
                    state_next = ST_LOWPWR;
            end
            ST_LOWPWR: begin
                if (unmasked || (lp_pin != lp_pin_at_entry_reg))
                    state_next = ST_ACTIVE;
            end
            default: state_next = ST_OFF;
        endcase
        if (state_reg != ST_OFF) begin
            // Power drops with hold low unless a pulse or ack keeps it
            if (!mon_ok && state_reg != ST_SEQ)
                state_next = ST_OFF;
            else if (!hold && pulse_reg == 18'h0_0000 && !ack_pend_reg)
                state_next = ST_OFF;
            else if (ack_reg == 18'h0_0001 && tick_reg)
                state_next = ST_OFF;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg           <= ST_OFF;
            lp_pin_at_entry_reg <= 1'b0;
            sts_prev_any_reg    <= 1'b0;
            pulse_reg           <= 18'h0_0000;
            ack_reg             <= 18'h0_0000;
            ack_pend_reg        <= 1'b0;
            o_device_reset      <= 1'b0;
        end else begin
            state_reg <= state_next;
            sts_prev_any_reg <= pending;
            if (state_reg != ST_LOWPWR)
                lp_pin_at_entry_reg <= lp_pin;
            // Button keeps power until hold arrives after a button start
            if (state_reg == ST_OFF && btn_fall)
                ack_pend_reg <= 1'b1;
            else if (hold || state_next == ST_OFF)
                ack_pend_reg <= 1'b0;
            if (state_reg == ST_OFF && new_int)
                pulse_reg <= PULSE_TICKS[17:0];
            else if (!pending)
                pulse_reg <= 18'h0_0000;
            else if (tick_reg && pulse_reg != 18'h0_0000)
                pulse_reg <= pulse_reg - 18'h0_0001;
            if (long_evt)
                ack_reg <= ACK_TICKS[17:0];
            else if (ctrl_reg[`PMUPS_CTRL_LP_ACK] ||
                     !sts_reg[`PMUPS_INT_LONGPR])
                ack_reg <= 18'h0_0000;
            else if (tick_reg && ack_reg != 18'h0_0000)
                ack_reg <= ack_reg - 18'h0_0001;
            o_device_reset <= btn_fall & i_otp_button_reset_mode;
        end
    end

    // ****************************************
    // Output stages
    // ****************************************
    wire int_level = unmasked ^ ~i_otp_int_active_high;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_processor_reset_output_n <= 1'b0;
            o_slow_clock_output        <= 1'b0;
            o_slow_clock_output_oe     <= 1'b0;
            o_host_interrupt_output    <= 1'b0;
            o_host_interrupt_output_oe <= 1'b0;
            o_spi_select               <= 1'b0;
            o_power_state              <= ST_OFF;
        end else begin
            o_processor_reset_output_n <= awake;
            o_slow_clock_output <= clk32_reg;
            o_slow_clock_output_oe <= ((state_reg == ST_SEQ) |
                (awake & ctrl_reg[`PMUPS_CTRL_CLKO_EN]));
            o_host_interrupt_output <= int_level;
            // Open drain, or push-pull with no I/O supply, drives low only
            o_host_interrupt_output_oe <= ~int_level |
                (~i_otp_int_open_drain & i_io_supply_ok);
            o_spi_select <= ~i_interface_select_strap;
            o_power_state <= state_reg;
        end
    end

endmodule

`default_nettype wire

// *** pmups_defs.vh ***
// Purpose: Constants for the power-state signal controller
// Assumes: 100 MHz system clock, Avalon-MM register access
// Notes:   Byte offsets are word aligned
`ifndef PMUPS_DEFS_VH
`define PMUPS_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define PMUPS_OFS_CTRL      4'h0
`define PMUPS_OFS_CTRL_B    4'h4
`define PMUPS_OFS_INT_STS   4'h8
`define PMUPS_OFS_INT_MSK   4'hC

// ****************************************
// Control register fields
// ****************************************
`define PMUPS_CTRL_SW_LP    0
`define PMUPS_CTRL_CLKO_EN  1
`define PMUPS_CTRL_LP_OFF   2
`define PMUPS_CTRL_MON_SEQ  3
`define PMUPS_CTRL_LP_ACK   4
`define PMUPS_CTRLB_PIN_EN  0
`define PMUPS_CTRLB_PIN_POL 1
`define PMUPS_CTRLB_HOLD_R  2
`define PMUPS_CTRLB_HOLD_F  3

// ****************************************
// Interrupt bits
// ****************************************
`define PMUPS_INT_BUTTON    0
`define PMUPS_INT_LONGPR    1
`define PMUPS_INT_HOLD      2
`define PMUPS_INT_WIDTH     3
`define PMUPS_MSK_RESET     3'h7

// ****************************************
// Timing
// ****************************************
`define PMUPS_CLK_HZ        100000000
`define PMUPS_SLOW_DIV      3052
`define PMUPS_DEB_TICKS     8'h40
`define PMUPS_LONG_S        5
`define PMUPS_ACK_S         1
`define PMUPS_PULSE_S       5
`define PMUPS_SLOW_HZ       32768

`endif

// *** pmups_ctrl_sva.sv ***
// Purpose: Port assertions for the power-state pin controller
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Attached to every controller instance by bind
`timescale 1ns/1ps
`default_nettype none

module pmups_ctrl_sva (
    // Clock, reset and bus
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic       i_avs_read,
    input wire logic       i_avs_write,
    input wire logic       o_avs_waitrequest,
    // Pins and state
    input wire logic       i_lowpower_pin,
    input wire logic       i_interface_select_strap,
    input wire logic       i_io_supply_ok,
    input wire logic       i_otp_int_open_drain,
    input wire logic       o_processor_reset_output_n,
    input wire logic       o_host_interrupt_output,
    input wire logic       o_host_interrupt_output_oe,
    input wire logic       o_spi_select,
    input wire logic [1:0] o_power_state
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence req_rise_s;
        $rose(i_avs_read || i_avs_write);
    endsequence
    sequence accept_s;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence

    bus_answer_a: assert property (req_rise_s |=> accept_s)
        else $error("bus request not answered after one cycle");
    idle_wait_a: assert property (!(i_avs_read || i_avs_write)
        |=> o_avs_waitrequest) else $error("waitrequest low while idle");
    reset_hold_a: assert property (!o_power_state[1]
        && !$past(o_power_state[1]) |-> !o_processor_reset_output_n)
        else $error("processor reset released before active");
    active_rel_a: assert property (o_power_state[1]
        && $past(o_power_state[1]) |-> o_processor_reset_output_n)
        else $error("processor reset held while awake");
    spi_map_a: assert property ($past(i_rst_n)
        |-> o_spi_select == !$past(i_interface_select_strap))
        else $error("shared pin owner differs from strap");
    odrain_out_a: assert property ((i_otp_int_open_drain
        || !i_io_supply_ok) && $stable(i_io_supply_ok)
        && o_host_interrupt_output_oe |-> !o_host_interrupt_output)
        else $error("interrupt pin driven high without high side");
    lp_wake_a: assert property (o_power_state == 2'h3
        && $changed(i_lowpower_pin) |-> ##[1:60] o_power_state != 2'h3)
        else $error("low-power pin change did not wake");
    lp_entry_a: assert property (o_power_state == 2'h3
        && $past(o_power_state) != 2'h3 |-> $past(o_power_state) == 2'h2)
        else $error("low-power entered from a state other than active");
endmodule

bind pmups_ctrl pmups_ctrl_sva chk_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
    .i_lowpower_pin(i_lowpower_pin), .i_io_supply_ok(i_io_supply_ok),
    .i_interface_select_strap(i_interface_select_strap),
    .i_otp_int_open_drain(i_otp_int_open_drain),
    .o_processor_reset_output_n(o_processor_reset_output_n),
    .o_host_interrupt_output(o_host_interrupt_output),
    .o_host_interrupt_output_oe(o_host_interrupt_output_oe),
    .o_spi_select(o_spi_select), .o_power_state(o_power_state));
`default_nettype wire

// *** pmups_far_model.sv ***
// Purpose: Button and host power-hold model on the far side
// Assumes: Commands from the bench change after a rising edge
// Notes:   A press chatters a few cycles before it settles
`timescale 1ns/1ps
`default_nettype none

module pmups_far_model (
    // Commands
    input  wire logic i_clk,
    input  wire logic i_press,
    input  wire logic i_hold_req,
    // Pins toward the device
    output var logic  o_push_button_input = 1'b1,
    output var logic  o_power_hold_input = 1'b0
);
    // ****************************************
    // Button contact and hold level
    // ****************************************
    logic [2:0] bounce_reg = 3'h0;
    logic       press_reg  = 1'b0;

    always @(posedge i_clk) begin
        press_reg <= i_press;
        if (i_press && !press_reg) begin
            bounce_reg <= 3'h6;
        end else if (bounce_reg != 3'h0) begin
            bounce_reg <= bounce_reg - 3'h1;
        end
        // Chatter makes the device rely on its own debounce
        o_push_button_input <= (bounce_reg != 3'h0) ? bounce_reg[0] : !i_press;
        o_power_hold_input <= i_hold_req;
    end
endmodule
`default_nettype wire

// *** pmu_power_state_signals_bench.sv ***
// Purpose: Self-checking bench of the power-state pin controller
// Assumes: Shortened slow divider and long-press counts
// Notes:   Slow tick every 4 clocks; debounce takes 260 clocks
`timescale 1ns/1ps
`default_nettype none
`include "pmups_defs.vh"

module pmu_power_state_signals_bench;
    logic        i_clk = 1'b0, i_rst_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd_data;
    logic        wait_req, lp_pin = 1'b0, press = 1'b0, hold_req = 1'b0;
    logic        io_ok = 1'b1, mon = 1'b1, button, hold, rst_out_n;
    logic        sclk, irq, irq_oe, sclk_oe, spi_sel, dev_rst;
    logic        strap_b = 1'b1, sel_strap = 1'b1, rst_mode = 1'b0;
    logic [1:0]  state;
    int          bad_count = 0, n_tests = 0, cyc = 0, k;

    always #5 i_clk = ~i_clk;

    pmups_far_model far_u (.i_clk(i_clk), .i_press(press),
        .i_hold_req(hold_req), .o_push_button_input(button),
        .o_power_hold_input(hold));

    pmups_ctrl #(.SLOW_DIV(4), .LONG_TICKS(40), .ACK_TICKS(20),
        .PULSE_TICKS(20)) dut_u (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(avs_address),
        .i_avs_read(avs_read), .i_avs_write(avs_write),
        .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
        .o_avs_waitrequest(wait_req), .i_lowpower_pin(lp_pin),
        .i_power_hold_input(hold), .i_push_button_input(button),
        .i_voltage_monitor_output(mon), .i_config_strap_b(strap_b),
        .i_interface_select_strap(sel_strap), .i_io_supply_ok(io_ok),
        .i_otp_button_reset_mode(rst_mode), .i_otp_int_open_drain(1'b0),
        .i_otp_int_active_high(1'b0), .o_processor_reset_output_n(rst_out_n),
        .o_slow_clock_output(sclk), .o_slow_clock_output_oe(sclk_oe),
        .o_host_interrupt_output(irq), .o_host_interrupt_output_oe(irq_oe),
        .o_spi_select(spi_sel), .o_device_reset(dev_rst),
        .o_power_state(state));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_sim;
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc++;
        // Whole run needs well under this many cycles
        if (cyc == 40000) begin
            bad_count++;
            end_sim;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge i_clk); while (wait_req !== 1'b0);
        rd_data = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wait_state(input logic [1:0] s, input int lim);
        k = 0;
        while (state !== s && k < lim) begin
            @(posedge i_clk);
            k++;
        end
    endtask

    task automatic count_clk(input int n);
        logic last;
        last = sclk;
        k = 0;
        repeat (n) begin
            @(posedge i_clk);
            // Only toggles actually driven onto the pin count
            if (sclk_oe === 1'b1 && sclk !== last) k++;
            last = sclk;
        end
    endtask

    // Press, release, then wait out the release debounce
    task automatic tap(input int n);
        press <= 1'b1;
        repeat (n) @(posedge i_clk);
        press <= 1'b0;
        repeat (300) @(posedge i_clk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_regs;
        bus(0, `PMUPS_OFS_INT_MSK, 0);
        chk(rd_data, 32'h0000_0007);
        bus(0, `PMUPS_OFS_CTRL_B, 0);
        chk(rd_data & 32'h0000_0003, 32'h0000_0000);
        bus(1, 4'h2, 32'hFFFF_FFFF);
        bus(0, 4'h2, 0);
        chk(rd_data, 32'h0000_0000);
        chk(spi_sel, 1'b0);
        sel_strap <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk(spi_sel, 1'b1);
    endtask

    task automatic s_power;
        press <= 1'b1;
        wait_state(2'h2, 3000);
        chk(state, 2'h2);
        hold_req <= 1'b1; // host keeps power
        press <= 1'b0;
        repeat (300) @(posedge i_clk);
        chk(rst_out_n, 1'b1);
        bus(1, `PMUPS_OFS_INT_STS, 32'h0000_0007);
        tap(400);
        bus(0, `PMUPS_OFS_INT_STS, 0);
        chk(rd_data & 32'h0000_0001, 32'h0000_0001);
        bus(1, `PMUPS_OFS_CTRL_B, 32'h0000_0008);
        hold_req <= 1'b0;
        wait_state(2'h0, 400);
        chk(state, 2'h0);
        bus(0, `PMUPS_OFS_INT_STS, 0);
        chk(rd_data & 32'h0000_0004, 32'h0000_0004);
        hold_req <= 1'b1;
        wait_state(2'h2, 3000);
        chk(state, 2'h2);
    endtask

    task automatic s_lowpower;
        bus(1, `PMUPS_OFS_INT_STS, 32'h0000_0007);
        bus(1, `PMUPS_OFS_CTRL_B, 32'h0000_0003);
        strap_b <= 1'b0;
        lp_pin <= 1'b1;
        repeat (40) @(posedge i_clk);
        chk(state, 2'h2);
        strap_b <= 1'b1;
        wait_state(2'h3, 200);
        chk(state, 2'h3);
        lp_pin <= 1'b0;
        wait_state(2'h2, 200);
        chk(state, 2'h2);
        bus(1, `PMUPS_OFS_CTRL_B, 0);
    endtask

    task automatic s_sleep;
        bus(1, `PMUPS_OFS_CTRL, 32'h0000_0001);
        wait_state(2'h3, 200);
        chk(state, 2'h3);
        tap(400);
        chk(state, 2'h3);
        chk(irq, 1'b1);
        bus(1, `PMUPS_OFS_INT_MSK, 32'h0000_0006);
        wait_state(2'h2, 200);
        chk(state, 2'h2);
        chk(irq, 1'b0);
        bus(1, `PMUPS_OFS_INT_STS, 32'h0000_0007);
        repeat (3) @(posedge i_clk);
        chk(irq, 1'b1);
        io_ok <= 1'b0;
        repeat (4) @(posedge i_clk);
        chk(irq_oe, 1'b0);
        io_ok <= 1'b1;
    endtask

    task automatic s_misc;
        bus(1, `PMUPS_OFS_CTRL, 32'h0000_0002);
        repeat (4) @(posedge i_clk);
        count_clk(40);
        chk(k, 10);
        chk(sclk_oe, 1'b1);
        bus(1, `PMUPS_OFS_CTRL, 32'h0000_0000);
        repeat (4) @(posedge i_clk);
        count_clk(40);
        chk(k, 0);
        chk(sclk_oe, 1'b0);
        bus(1, `PMUPS_OFS_CTRL, 32'h0000_0008);
        mon <= 1'b0;
        wait_state(2'h0, 400);
        chk(state, 2'h0);
        mon <= 1'b1;
        wait_state(2'h2, 3000);
        chk(state, 2'h2);
        bus(1, `PMUPS_OFS_CTRL, 32'h0000_0004);
        press <= 1'b1;
        wait_state(2'h0, 3000);
        chk(state, 2'h0);
        press <= 1'b0;
        bus(0, `PMUPS_OFS_INT_STS, 0);
        chk(rd_data & 32'h0000_0002, 32'h0000_0002);
        repeat (300) @(posedge i_clk);
        rst_mode <= 1'b1;
        press <= 1'b1;
        k = 0;
        repeat (400) begin
            @(posedge i_clk);
            if (dev_rst === 1'b1) k++;
        end
        press <= 1'b0;
        chk(k, 1);
    endtask

    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        chk(state, 2'h0);
        s_regs;
        s_power;
        s_lowpower;
        s_sleep;
        s_misc;
        end_sim;
    end
endmodule
`default_nettype wire
